// ### slave_address_auto_detect.sv
// Function
// - store discovered slave ids in nonvolatile memory
// - refresh slave parameters after ids stored
// - stored id list kept until next scan
// - unset/duplicate and parameter records are volatile
// - held push button starts scan at lamp
// - scan-active flag high for whole scan
// - lamp flashes during storing, then off
// - no scan under hardware, drop, short errors
// - no scan during five second settling
// - no scan while adjustment mode active
// - ignore request if access busy or scanning
// - ascending ids, stop at maximum count
// - halt io transfer during scan
// - detection starts 0.5 s after lamp off
// - alarm and access fault latched until clear
// - publish error id, count, id list
// - error flags clear only once cause removed
// - ready drops on error, returns after clear
`timescale 1ns/100ps
module slave_address_auto_detect
  import auto_detect_pkg::*;
#(
  parameter int unsigned SETTLE = SETTLE_CYCLES,
  parameter int unsigned DETECT_DELAY = DETECT_DELAY_CYCLES,
  parameter int unsigned HOLD = HOLD_CYCLES,
  parameter int unsigned SHOW = SHOW_CYCLES,
  parameter int unsigned FLASH = FLASH_CYCLES,
  parameter int unsigned MAX_COUNT = MAX_SLAVES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_set_button,
  input wire logic i_scan_request_cmd,
  input wire logic i_error_clear_request,
  input wire logic i_adjustment_active_flag,
  input wire logic i_param_access_done,
  input wire logic [15:0] i_error_code,
  input wire logic i_probe_done,
  input wire logic i_probe_present,
  input wire logic i_probe_bad,
  input wire logic i_nv_ack,
  input wire logic i_param_refresh_done,
  input wire logic i_param_refresh_fault,
  input wire logic [7:0] i_rw_addr,
  output status_flags_t o_flags,
  output logic o_lamp,
  output logic o_io_halt,
  output probe_req_t o_probe,
  output nv_write_t o_nv,
  output logic o_param_refresh,
  output logic [15:0] o_rw_data
);
  scan_state_t state;
  scan_state_t next_state;
  logic [31:0] timer;
  logic [31:0] settle_cnt;
  logic settled;
  logic [31:0] hold_cnt;
  logic btn_s1;
  logic btn_s2;
  logic btn_s3;
  logic btn_level;
  logic btn_fire;
  logic cmd_q;
  logic cmd_fall;
  logic err_block;
  logic allowed;
  logic start;
  logic [9:0] cand;
  logic waiting;
  logic sweep_done;
  logic [15:0] count;
  logic [15:0] latest_err;
  logic [31:0] flash_cnt;
  logic [15:0] id_table [0:MAX_SLAVES-1];
  logic [7:0] idx;
  logic store_done;
  logic refresh_sent;
  logic set_alarm;
  logic set_pfault;
  logic clr_seen;
  logic probe_ok;

  assign err_block = (i_error_code >= ERR_HW_FIRST && i_error_code <= ERR_HW_LAST) ||
                     i_error_code == ERR_LINE_DROP || i_error_code == ERR_LINE_SHORT;
  assign allowed = !err_block && settled && !i_adjustment_active_flag &&
                   i_param_access_done && !o_flags.scan_active;
  assign cmd_fall = cmd_q && !i_scan_request_cmd;
  assign btn_fire = btn_level && hold_cnt == 32'(HOLD - 1);
  assign start = state == ST_IDLE && allowed && (btn_fire || cmd_fall);
  assign probe_ok = waiting && i_probe_done;
  assign set_alarm = state == ST_DETECT && probe_ok && i_probe_bad;
  assign set_pfault = state == ST_REFRESH && i_param_refresh_done && i_param_refresh_fault;
  assign store_done = o_nv.wr && i_nv_ack && idx == count[7:0];

  // settling window after power-on or reset release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_cnt <= 32'h0;
      settled <= 1'b0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + 32'h1;
      settled <= settle_cnt == 32'(SETTLE - 1);
    end
  end

  // push button: three stages, level changes when the last two agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
      btn_s3 <= 1'b0;
      btn_level <= 1'b0;
      hold_cnt <= 32'h0;
      cmd_q <= 1'b0;
    end else begin
      btn_s1 <= i_set_button;
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
      if (btn_s2 == btn_s3) begin
        btn_level <= btn_s3;
      end
      if (!btn_level) begin
        hold_cnt <= 32'h0;
      end else if (hold_cnt != 32'(HOLD)) begin
        hold_cnt <= hold_cnt + 32'h1;
      end
      cmd_q <= i_scan_request_cmd;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_SHOW;
        end
      end
      ST_SHOW: begin
        if (timer == 32'(SHOW - 1)) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (timer == 32'(DETECT_DELAY - 1)) begin
          next_state = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (sweep_done) begin
          next_state = ST_STORE;
        end
      end
      ST_STORE: begin
        if (store_done) begin
          next_state = ST_REFRESH;
        end
      end
      ST_REFRESH: begin
        if (refresh_sent && i_param_refresh_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      timer <= 32'h0;
      o_io_halt <= 1'b0;
    end else begin
      state <= next_state;
      timer <= (next_state != state) ? 32'h0 : timer + 32'h1;
      o_io_halt <= next_state != ST_IDLE;
    end
  end

  // lamp: steady in show phase, flashing while storing, dark otherwise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lamp <= 1'b0;
    end else if (next_state == ST_SHOW) begin
      o_lamp <= 1'b1;
    end else if (next_state == ST_STORE) begin
      if (state != ST_STORE || flash_cnt == 32'(FLASH - 1)) begin
        o_lamp <= !o_lamp;
      end
    end else begin
      o_lamp <= 1'b0;
    end
  end

  // flash period counter, restarts on store entry
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flash_cnt <= 32'h0;
    end else if (state != ST_STORE || flash_cnt == 32'(FLASH - 1)) begin
      flash_cnt <= 32'h0;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  // ascending sweep over output then input id ranges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_probe <= '0;
      cand <= 10'h0;
      waiting <= 1'b0;
      sweep_done <= 1'b0;
      count <= 16'h0;
      latest_err <= 16'h0;
      for (int i = 0; i < MAX_SLAVES; i++) begin
        id_table[i] <= 16'h0;
      end
    end else begin
      o_probe.req <= 1'b0;
      if (state == ST_DELAY) begin
        cand <= 10'h0;
        waiting <= 1'b0;
        sweep_done <= 1'b0;
        count <= 16'h0;
      end else if (state == ST_DETECT && !sweep_done) begin
        if (!waiting) begin
          o_probe.req <= 1'b1;
          o_probe.id <= cand;
          waiting <= 1'b1;
        end else if (i_probe_done) begin
          waiting <= 1'b0;
          if (i_probe_bad) begin
            latest_err <= {6'h0, cand};
          end else if (i_probe_present) begin
            id_table[count[6:0]] <= {6'h0, cand};
            count <= count + 16'h1;
          end
          if (cand == IN_ID_LAST ||
              (i_probe_present && !i_probe_bad && count == 16'(MAX_COUNT - 1))) begin
            sweep_done <= 1'b1;
          end
          cand <= (cand == OUT_ID_LAST) ? IN_ID_FIRST : cand + 10'h1;
        end
      end
    end
  end

  // nonvolatile write: count word first, then each table entry
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_nv <= '0;
      idx <= 8'h0;
    end else if (state != ST_STORE) begin
      o_nv.wr <= 1'b0;
      idx <= 8'h0;
    end else if (o_nv.wr) begin
      if (i_nv_ack) begin
        o_nv.wr <= 1'b0;
        idx <= idx + 8'h1;
      end
    end else if (idx <= count[7:0]) begin
      o_nv.wr <= 1'b1;
      o_nv.addr <= NV_COUNT_ADDR + idx;
      o_nv.data <= (idx == 8'h0) ? count : id_table[7'(idx - 8'h1)];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_param_refresh <= 1'b0;
      refresh_sent <= 1'b0;
    end else begin
      o_param_refresh <= state == ST_REFRESH && !refresh_sent;
      refresh_sent <= state == ST_REFRESH;
    end
  end

  // status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flags <= '0;
      o_flags.remote_ready <= 1'b1;
      clr_seen <= 1'b0;
    end else begin
      o_flags.scan_active <= next_state != ST_IDLE;
      if (set_alarm) begin
        o_flags.slave_alarm <= 1'b1;
      end else if (i_error_clear_request && state == ST_IDLE) begin
        o_flags.slave_alarm <= 1'b0;
      end
      if (set_pfault) begin
        o_flags.param_fault <= 1'b1;
      end else if (i_error_clear_request && state == ST_IDLE) begin
        o_flags.param_fault <= 1'b0;
      end
      if (err_block || set_alarm || set_pfault) begin
        o_flags.remote_ready <= 1'b0;
        clr_seen <= 1'b0;
      end else if (!o_flags.remote_ready) begin
        if (i_error_clear_request) begin
          clr_seen <= 1'b1;
        end else if (clr_seen && !o_flags.slave_alarm && !o_flags.param_fault) begin
          o_flags.remote_ready <= 1'b1;
          clr_seen <= 1'b0;
        end
      end
    end
  end

  // remote register words
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rw_data <= 16'h0;
    end else if (i_rw_addr == RW_LATEST_ERR) begin
      o_rw_data <= latest_err;
    end else if (i_rw_addr == RW_COUNT) begin
      o_rw_data <= count;
    end else if (i_rw_addr >= RW_TABLE && i_rw_addr < RW_TABLE + 8'(MAX_SLAVES)) begin
      o_rw_data <= id_table[7'(i_rw_addr - RW_TABLE)];
    end else begin
      o_rw_data <= 16'h0;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence refresh_end;
    state == ST_REFRESH && refresh_sent ##0 i_param_refresh_done;
  endsequence

  sequence remote_req;
    state == ST_IDLE && allowed ##0 cmd_fall;
  endsequence

  AST_NO_SCAN_ON_FAULT: assert property (
    state == ST_IDLE && err_block |=> state == ST_IDLE) else $error("scan started under error");
  AST_NO_SCAN_SETTLING: assert property (
    !settled |-> !o_flags.scan_active) else $error("scan during settling");
  AST_NO_SCAN_ADJUST: assert property (
    state == ST_IDLE && i_adjustment_active_flag |=> state == ST_IDLE) else $error("scan in adjust");
  AST_IGNORE_BUSY: assert property (
    state == ST_IDLE && !i_param_access_done |=> !o_flags.scan_active) else $error("busy req taken");
  AST_REQ_ON_FALL: assert property (
    remote_req |=> state == ST_SHOW ##1 o_flags.scan_active && o_lamp) else $error("req missed");
  AST_SCAN_ENDS: assert property (
    refresh_end |=> state == ST_IDLE ##0 !o_flags.scan_active) else $error("active not cleared");
  AST_LAMP_OFF_STORED: assert property (
    store_done |=> !o_lamp [*2]) else $error("lamp lit after store");
  AST_DETECT_DELAY: assert property (
    state == ST_DELAY && !o_lamp |-> !o_probe.req) else $error("probe before delay");
  AST_HALT_IO: assert property (
    state != ST_IDLE |-> o_io_halt) else $error("io not halted");
  AST_COUNT_MAX: assert property (
    count <= 16'(MAX_COUNT)) else $error("count above maximum");
endmodule

// ### auto_detect_pkg.sv
package auto_detect_pkg;
  localparam int unsigned CLK_FREQ_KHZ = 100_000;
  localparam int unsigned SETTLE_TIME_MS = 5000;
  localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned DETECT_DELAY_MS = 500;
  localparam int unsigned DETECT_DELAY_CYCLES = DETECT_DELAY_MS * CLK_FREQ_KHZ;
  localparam int unsigned HOLD_TIME_MS = 1000;
  localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned SHOW_TIME_MS = 500;
  localparam int unsigned SHOW_CYCLES = SHOW_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned FLASH_TIME_MS = 250;
  localparam int unsigned FLASH_CYCLES = FLASH_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned MAX_SLAVES = 128;
  // remote register word offsets, then nonvolatile count address
  localparam logic [7:0] RW_LATEST_ERR = 8'h01;
  localparam logic [7:0] RW_COUNT = 8'h02;
  localparam logic [7:0] RW_TABLE = 8'h03;
  localparam logic [7:0] NV_COUNT_ADDR = 8'h00;
  // slave id space, searched in ascending order
  localparam logic [9:0] OUT_ID_LAST = 10'h0fe;
  localparam logic [9:0] IN_ID_FIRST = 10'h200;
  localparam logic [9:0] IN_ID_LAST = 10'h2fe;
  // error codes that block a scan
  localparam logic [15:0] ERR_HW_FIRST = 16'h0064;
  localparam logic [15:0] ERR_HW_LAST = 16'h0067;
  localparam logic [15:0] ERR_LINE_DROP = 16'h00c8;
  localparam logic [15:0] ERR_LINE_SHORT = 16'h00c9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHOW = 3'b001,
    ST_DELAY = 3'b011,
    ST_DETECT = 3'b010,
    ST_STORE = 3'b110,
    ST_REFRESH = 3'b111
  } scan_state_t;

  typedef struct packed {
    logic remote_ready;
    logic param_fault;
    logic slave_alarm;
    logic scan_active;
  } status_flags_t;

  typedef struct packed {
    logic req;
    logic [9:0] id;
  } probe_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] data;
  } nv_write_t;
endpackage

// ### far_side_model.sv
`timescale 1ns/100ps
module far_side_model
  import auto_detect_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire probe_req_t i_probe,
  input wire logic [39:0] i_ids,
  input wire logic [9:0] i_bad_id,
  input wire logic i_fault,
  input wire nv_write_t i_nv,
  input wire logic i_param_refresh,
  output logic o_probe_done,
  output logic o_probe_present,
  output logic o_probe_bad,
  output logic o_nv_ack,
  output logic o_param_refresh_done,
  output logic o_param_refresh_fault
);
  logic [1:0] pwait;
  logic [2:0] rwait;
  logic [9:0] pid;
  logic hit, junk, done, rdone;
  always_comb begin
    hit = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (i_ids[k*10 +: 10] == pid) hit = 1'b1;
    end
  end
  // answer lines toggle when not qualified by done
  assign o_probe_done = done;
  assign o_probe_present = done ? hit : junk;
  assign o_probe_bad = done ? (pid == i_bad_id) : ~junk;
  assign o_param_refresh_done = rdone;
  assign o_param_refresh_fault = rdone ? i_fault : junk;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {pwait, rwait, pid, junk, done, rdone, o_nv_ack} <= '0;
    end else begin
      junk <= ~junk;
      done <= 1'b0;
      rdone <= 1'b0;
      // odd ids answered one cycle slower
      if (i_probe.req) begin
        pid <= i_probe.id;
        pwait <= {1'b0, i_probe.id[0]} + 2'd1;
      end else if (pwait != 2'd0) begin
        pwait <= pwait - 2'd1;
        done <= (pwait == 2'd1);
      end
      o_nv_ack <= i_nv.wr & ~o_nv_ack & junk;
      if (i_param_refresh) begin
        rwait <= 3'd4;
      end else if (rwait != 3'd0) begin
        rwait <= rwait - 3'd1;
        rdone <= (rwait == 3'd1);
      end
    end
  end
endmodule

// ### slave_address_auto_detect_tb_top.sv
`timescale 1ns/100ps
module slave_address_auto_detect_tb_top;
  import auto_detect_pkg::*;
  localparam int MAXC = 3;
  logic clk = 0, rst = 1, btn = 0, cmd = 0, clr = 0, adj = 0, pad = 1, flt = 0;
  logic [15:0] ecode = '0;
  logic [7:0] rwa = '0;
  logic [39:0] ids = '0;
  logic [9:0] bad_id = 10'h3ff;
  status_flags_t flags;
  probe_req_t probe;
  nv_write_t nv;
  logic lamp, halt, refr, pdone, ppres, pbad, nack, rdone, rfault;
  logic [15:0] rwd;
  logic [23:0] expq[$];
  logic [31:0] seed = 32'haf6d8e17;
  logic [15:0] codes[6] = '{ERR_HW_FIRST, 16'h0065, 16'h0066, ERR_HW_LAST,
                            ERR_LINE_DROP, ERR_LINE_SHORT};
  int n_fail = 0, n_tests = 0, cyc = 0, nref = 0, nlit = 0, ndark = 0;

  slave_address_auto_detect #(.SETTLE(50), .DETECT_DELAY(20), .HOLD(10), .SHOW(10),
    .FLASH(4), .MAX_COUNT(MAXC)) i_slave_address_auto_detect (.i_clk(clk), .i_rst(rst),
    .i_set_button(btn), .i_scan_request_cmd(cmd), .i_error_clear_request(clr),
    .i_adjustment_active_flag(adj), .i_param_access_done(pad), .i_error_code(ecode),
    .i_probe_done(pdone), .i_probe_present(ppres), .i_probe_bad(pbad), .i_nv_ack(nack),
    .i_param_refresh_done(rdone), .i_param_refresh_fault(rfault), .i_rw_addr(rwa),
    .o_flags(flags), .o_lamp(lamp), .o_io_halt(halt), .o_probe(probe), .o_nv(nv),
    .o_param_refresh(refr), .o_rw_data(rwd));

  far_side_model i_far_side_model (.i_clk(clk), .i_rst(rst), .i_probe(probe),
    .i_ids(ids), .i_bad_id(bad_id), .i_fault(flt), .i_nv(nv), .i_param_refresh(refr),
    .o_probe_done(pdone), .o_probe_present(ppres), .o_probe_bad(pbad), .o_nv_ack(nack),
    .o_param_refresh_done(rdone), .o_param_refresh_fault(rfault));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse_cmd();
    cmd = 1'b1;
    cyc_n(1);
    cmd = 1'b0;
    cyc_n(1);
  endtask

  task automatic clear_err();
    clr = 1'b1;
    cyc_n(2);
    clr = 1'b0;
    cyc_n(2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rwa = a;
    cyc_n(1);
    chk("register word", {8'h0, exp}, {8'h0, rwd});
  endtask

  // new random slave set; expected store notes queued in ascending order
  task automatic new_scan();
    ids = {10'h2fe, 10'h200 + 10'(xs() % 128), 10'h080 + 10'(xs() % 127), 10'(xs() % 127)};
    expq.push_back({8'h00, 16'(MAXC)});
    for (int k = 0; k < MAXC; k++) begin
      expq.push_back({8'(k + 1), 6'h0, ids[k*10 +: 10]});
    end
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    while (flags.scan_active !== 1'b0 && i < 8000) begin
      cyc_n(1);
      i++;
    end
    chk("scan end", 24'h0, {23'h0, flags.scan_active});
    chk("store notes left", 24'h0, 24'(expq.size()));
  endtask

  always @(posedge clk) begin
    cyc++;
    if (refr === 1'b1) nref++;
    if (nv.wr === 1'b1 && lamp === 1'b1) nlit++;
    if (nv.wr === 1'b1 && lamp === 1'b0) ndark++;
    if (nv.wr === 1'b1 && nack === 1'b1) begin
      if (expq.size() == 0) begin
        chk("surplus store", 24'h0, {nv.addr, nv.data});
      end else begin
        chk("stored word", expq.pop_front(), {nv.addr, nv.data});
      end
    end
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    cyc_n(6);
    rst = 1'b0;
    chk("ready", 24'h1, {23'h0, flags.remote_ready});
    pulse_cmd();
    cyc_n(4);
    chk("settle refuse", 24'h0, {23'h0, flags.scan_active});
    cyc_n(60);
    $display("test settle done");
    for (int i = 0; i < 8; i++) begin
      if (i < 6) ecode = codes[i];
      adj = (i == 6);
      pad = (i != 7);
      cyc_n(2);
      pulse_cmd();
      cyc_n(4);
      chk("refuse", 24'h0, {23'h0, flags.scan_active});
      if (i < 6) chk("ready drop", 24'h0, {23'h0, flags.remote_ready});
      ecode = '0;
      adj = 1'b0;
      pad = 1'b1;
      clear_err();
      chk("ready back", 24'h1, {23'h0, flags.remote_ready});
    end
    $display("test refusals done");
    new_scan();
    pulse_cmd();
    cyc_n(3);
    chk("start", 24'h7, {21'h0, flags.scan_active, lamp, halt});
    pulse_cmd();
    wait_idle();
    chk("after scan", 24'h0, {22'h0, lamp, halt});
    chk("refresh", 24'h1, 24'(nref));
    chk("lamp flash", 24'h1, {23'h0, nlit > 0 && ndark > 0});
    cyc_n(5);
    chk("no rescan", 24'h0, {23'h0, flags.scan_active});
    rd(RW_COUNT, 16'(MAXC));
    rd(RW_TABLE, {6'h0, ids[9:0]});
    rd(RW_TABLE + 8'h02, {6'h0, ids[29:20]});
    rd(8'hf0, 16'h0);
    $display("test remote scan done");
    bad_id = 10'h07f;
    flt = 1'b1;
    new_scan();
    btn = 1'b1;
    for (int i = 0; i < 100 && lamp !== 1'b1; i++) cyc_n(1);
    btn = 1'b0;
    chk("button start", 24'h1, {23'h0, flags.scan_active});
    wait_idle();
    cyc_n(20);
    chk("latched", 24'h6, {21'h0, flags.param_fault, flags.slave_alarm,
      flags.remote_ready});
    rd(RW_LATEST_ERR, 16'h007f);
    clear_err();
    chk("cleared", 24'h1, {21'h0, flags.param_fault, flags.slave_alarm,
      flags.remote_ready});
    $display("test button scan done");
    give_verdict();
  end
endmodule
